// File: rtl/aui_pls_line.sv
// Station-side line signalling: Manchester encode and decode,
// control circuit symbols, carrier and error sense, quality test.
// Assumes line pins are asynchronous; registers on Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module aui_pls_line (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // MAC transmit byte stream
  input  wire logic        macTxValid,
  input  wire logic [7:0]  macTxData,
  output logic             macTxReady,
  // MAC receive and status
  output logic             rxValid,
  output logic             rxBit,
  output logic             carrierStatus,
  output logic             carrierChange,
  output logic             sqeStatus,
  output logic             sqeChange,
  // Management test result pulses
  output logic             sqeTestOk,
  output logic             sqeTestErr,
  // Line pins
  output logic             dataOut,
  output logic             dataOutEn,
  input  wire logic        dataIn,
  output logic             ctlOut,
  output logic             ctlOutEn,
  input  wire logic        ctlIn
);

  ////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisers
  logic [1:0] rstPipe;
  logic       rstSync_b;
  logic [1:0] rxPipe;
  logic [1:0] ciPipe;
  logic       rxPrev;
  logic       ciPrev;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rstPipe <= 2'h0;
    else        rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_b = rstPipe[1];

  // Pins pass two flops; only the second is read
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rxPipe <= 2'h0;
      ciPipe <= 2'h3;  // Control In rests high; no false edge
      rxPrev <= 1'b0;
      ciPrev <= 1'b1;
    end else begin
      rxPipe <= {rxPipe[0], dataIn};
      ciPipe <= {ciPipe[0], ctlIn};
      rxPrev <= rxPipe[1];
      ciPrev <= ciPipe[1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file
  logic busAck;
  logic monitor;
  logic lastOk;
  logic lastErr;
  logic winOpen;
  logic txBusy;
  logic mauAvail;
  logic [31:0] regMux;
  aui_pls_pkg::tx_state_type   txState;
  aui_pls_pkg::test_state_type testState;

  // Decode and read selection; unmapped reads as zero
  assign waitrequest = (read | write) & ~busAck;
  assign regMux =
    (address == aui_pls_pkg::REG_CTRL)   ? {31'h0, monitor} :
    (address == aui_pls_pkg::REG_STATUS) ?
      {27'h0, winOpen, mauAvail, txBusy, sqeStatus, carrierStatus} :
    (address == aui_pls_pkg::REG_RESULT) ? {30'h0, lastErr, lastOk} :
    32'h0;

  // One wait cycle per access; write lands on the ack edge
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      busAck   <= 1'b0;
      readdata <= 32'h0;
      monitor  <= aui_pls_pkg::CTRL_RESET;
    end else begin
      busAck <= (read | write) & ~busAck;
      if (read && !busAck) readdata <= regMux;
      if (write && busAck && address == aui_pls_pkg::REG_CTRL)
        monitor <= writedata[aui_pls_pkg::CTRL_MONITOR];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control In decode by edge spacing
  logic [5:0] ciCnt;
  logic       ciEdge;
  logic       sqeIn;
  aui_pls_pkg::sym_type ciSym;

  assign ciEdge   = ciPipe[1] ^ ciPrev;
  assign sqeIn    = (ciSym == aui_pls_pkg::SYM_CS0);
  assign mauAvail = (ciSym == aui_pls_pkg::SYM_IDL);

  // Short half period is CS0, long is CS1, silence is IDL
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ciCnt <= 6'h3F;
      ciSym <= aui_pls_pkg::SYM_IDL;
    end else if (ciEdge) begin
      ciCnt <= 6'h0;
      if (ciCnt < 6'(aui_pls_pkg::CS_SPLIT_CYC))
        ciSym <= aui_pls_pkg::SYM_CS0;
      else if (ciCnt < 6'(aui_pls_pkg::IDL_DET_CYC))
        ciSym <= aui_pls_pkg::SYM_CS1;
    end else begin
      if (ciCnt != 6'h3F) ciCnt <= ciCnt + 6'h1;
      if (ciCnt == 6'(aui_pls_pkg::IDL_DET_CYC - 1))
        ciSym <= aui_pls_pkg::SYM_IDL;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control Out encode
  logic [5:0] coCnt;
  logic [5:0] coPer;
  logic       coIdle;

  // Isolate beats request; request only while waiting on the unit
  assign coIdle = !monitor && txState != aui_pls_pkg::TX_REQ;
  assign coPer  = monitor ? 6'(aui_pls_pkg::HALF_CYC - 1)
                          : 6'(aui_pls_pkg::BIT_CYC - 1);

  // Even duty from the clock; idle ends high then releases
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      coCnt    <= 6'h0;
      ctlOut   <= 1'b0;
      ctlOutEn <= 1'b0;
    end else if (!coIdle) begin
      ctlOutEn <= 1'b1;
      if (coCnt >= coPer) begin
        coCnt  <= 6'h0;
        ctlOut <= ~ctlOut;
      end else coCnt <= coCnt + 6'h1;
    end else if (ctlOutEn) begin
      if (!ctlOut) begin
        ctlOut <= 1'b1;
        coCnt  <= 6'h0;
      end else if (coCnt >= 6'(aui_pls_pkg::IDL_HOLD_CYC - 1)) begin
        ctlOutEn <= 1'b0;
        ctlOut   <= 1'b0;
      end else coCnt <= coCnt + 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit framer and Manchester encoder
  logic [7:0] txShift;
  logic [5:0] txCnt;
  logic [2:0] bitIdx;
  logic [2:0] hdrCnt;
  logic       sending;
  logic       bitEnd;
  logic       byteEnd;
  logic       wantData;
  logic       txEnd;

  assign sending  = txState == aui_pls_pkg::TX_HDR ||
                    txState == aui_pls_pkg::TX_DATA;
  assign txBusy   = txState != aui_pls_pkg::TX_IDLE;
  assign bitEnd   = sending && txCnt == 6'(aui_pls_pkg::BIT_CYC - 1);
  assign byteEnd  = bitEnd && bitIdx == 3'h7;
  assign wantData = txState == aui_pls_pkg::TX_DATA ||
                    hdrCnt == aui_pls_pkg::HDR_LAST;
  assign macTxReady = byteEnd && wantData && macTxValid;

  // Header bytes, then MAC bytes while offered, then idle
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      txState <= aui_pls_pkg::TX_IDLE;
      txShift <= 8'h00;
      txCnt   <= 6'h0;
      bitIdx  <= 3'h0;
      hdrCnt  <= 3'h0;
      txEnd   <= 1'b0;
    end else begin
      txEnd <= 1'b0;
      unique case (txState)
        aui_pls_pkg::TX_IDLE: begin
          if (macTxValid && !monitor) txState <= aui_pls_pkg::TX_REQ;
        end
        aui_pls_pkg::TX_REQ: begin
          if (monitor) txState <= aui_pls_pkg::TX_IDLE;
          else if (mauAvail) begin
            txState <= aui_pls_pkg::TX_HDR;
            txShift <= aui_pls_pkg::PRE_BYTE;
            txCnt   <= 6'h0;
            bitIdx  <= 3'h0;
            hdrCnt  <= 3'h0;
          end
        end
        aui_pls_pkg::TX_HDR, aui_pls_pkg::TX_DATA: begin
          txCnt <= bitEnd ? 6'h0 : txCnt + 6'h1;
          if (bitEnd) begin
            bitIdx  <= bitIdx + 3'h1;
            txShift <= {1'b0, txShift[7:1]};
          end
          if (byteEnd) begin
            if (wantData && macTxValid) begin
              txState <= aui_pls_pkg::TX_DATA;
              txShift <= macTxData;
            end else if (wantData) begin
              txState <= aui_pls_pkg::TX_ETD;
            end else begin
              hdrCnt  <= hdrCnt + 3'h1;
              txShift <= (hdrCnt == aui_pls_pkg::HDR_LAST - 3'h1)
                         ? aui_pls_pkg::SFD_BYTE : aui_pls_pkg::PRE_BYTE;
            end
          end
        end
        aui_pls_pkg::TX_ETD: begin
          txCnt <= txCnt + 6'h1;
          if (txCnt == 6'(aui_pls_pkg::IDL_HOLD_CYC - 1)) begin
            txState <= aui_pls_pkg::TX_IDLE;
            txEnd   <= 1'b1;
          end
        end
      endcase
    end
  end

  // Line from flops; driver gated off whenever isolated
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end else begin
      dataOut <= sending
        ? (txCnt < 6'(aui_pls_pkg::HALF_CYC) ? ~txShift[0] : txShift[0])
        : (txState == aui_pls_pkg::TX_ETD);
      dataOutEn <= (sending || txState == aui_pls_pkg::TX_ETD)
                   && !monitor;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive decoder; works the same in monitor mode
  logic [5:0] rxCnt;
  logic       rxEdge;
  logic       rxActive;

  assign rxEdge = rxPipe[1] ^ rxPrev;

  // Mid-cell edges carry bits; boundary edges are skipped
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rxCnt    <= 6'h0;
      rxActive <= 1'b0;
      rxValid  <= 1'b0;
      rxBit    <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      // From silence only a rising edge starts carrier: the idle high
      // droops back low and must not be taken for a new frame
      if (rxEdge && (rxActive ? rxCnt >= 6'(aui_pls_pkg::MID_MIN_CYC - 1)
                              : rxPipe[1])) begin
        rxActive <= 1'b1;
        rxCnt    <= 6'h0;
        rxValid  <= 1'b1;
        rxBit    <= rxPipe[1];
      end else if (rxActive) begin
        rxCnt <= rxCnt + 6'h1;
        // Short enough that droop edges are not mistaken
        if (rxCnt == 6'(aui_pls_pkg::RX_IDL_CYC - 1))
          rxActive <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Error sense and carrier sense reporting
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sqeStatus     <= 1'b0;
      sqeChange     <= 1'b0;
      carrierStatus <= 1'b0;
      carrierChange <= 1'b0;
    end else begin
      sqeStatus <= sqeIn;
      sqeChange <= sqeIn != sqeStatus;
      // Frozen while the test window is open
      if (!winOpen) carrierStatus <= rxActive;
      carrierChange <= !winOpen && rxActive != carrierStatus;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Quality-error test after each transmission that saw carrier and no error signal
  logic [9:0] winCnt;
  logic       sawCarrier;
  logic       winPass;

  assign winOpen = testState == aui_pls_pkg::T_WIN;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      testState  <= aui_pls_pkg::T_IDLE;
      winCnt     <= 10'h0;
      sawCarrier <= 1'b0;
      winPass    <= 1'b0;
      sqeTestOk  <= 1'b0;
      sqeTestErr <= 1'b0;
      lastOk     <= 1'b0;
      lastErr    <= 1'b0;
    end else begin
      sqeTestOk  <= 1'b0;
      sqeTestErr <= 1'b0;
      unique case (testState)
        aui_pls_pkg::T_IDLE: begin
          if (txState == aui_pls_pkg::TX_REQ) begin
            testState  <= aui_pls_pkg::T_TX;
            sawCarrier <= 1'b0;
          end
        end
        aui_pls_pkg::T_TX: begin
          if (rxActive) sawCarrier <= 1'b1;
          if (sqeIn) testState <= aui_pls_pkg::T_IDLE;
          else if (txEnd)
            testState <= (sawCarrier || rxActive)
                         ? aui_pls_pkg::T_WAIT
                         : aui_pls_pkg::T_IDLE;
        end
        aui_pls_pkg::T_WAIT: begin
          if (sqeIn) testState <= aui_pls_pkg::T_IDLE;
          else if (!rxActive) begin
            testState <= aui_pls_pkg::T_WIN;
            winCnt    <= 10'h0;
            winPass   <= 1'b0;
          end
        end
        aui_pls_pkg::T_WIN: begin
          winCnt <= winCnt + 10'h1;
          if (sqeIn) winPass <= 1'b1;
          if (winCnt == 10'(aui_pls_pkg::WIN_CYC - 1)) begin
            testState  <= aui_pls_pkg::T_IDLE;
            sqeTestOk  <= winPass || sqeIn;
            sqeTestErr <= !(winPass || sqeIn);
            lastOk     <= winPass || sqeIn;
            lastErr    <= !(winPass || sqeIn);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_mon_isolate: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    monitor |=> !dataOutEn)
    else $error("driver on in monitor mode");

  a_manch_halves: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (sending && txCnt == 6'h0) |=> dataOut == !$past(txShift[0])
      ##10 dataOut == $past(txShift[0], 11))
    else $error("cell halves wrong");

  a_etd_high: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    $rose(txState == aui_pls_pkg::TX_ETD) |=> dataOut [*8] ##32 dataOut)
    else $error("idle not held high");

  a_rx_idle: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    $fell(rxActive) |-> !$past(rxEdge) && $past(rxCnt) == 6'h27)
    else $error("idle detect timing");

  // Window age for the length check; a delay that long is too slow
  logic [10:0] winAge;
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) winAge <= 11'h0;
    else            winAge <= winOpen ? winAge + 11'h1 : 11'h0;
  end

  a_win_len: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    $fell(winOpen) |->
      winAge >= 11'(aui_pls_pkg::WIN_MIN_NS / aui_pls_pkg::CLK_NS) &&
      winAge <= 11'(aui_pls_pkg::WIN_MAX_NS / aui_pls_pkg::CLK_NS) &&
      (sqeTestOk ^ sqeTestErr))
    else $error("window length or result");

  a_win_inhibit: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (winOpen && $past(winOpen)) |-> !carrierChange && $stable(carrierStatus))
    else $error("carrier reported in window");

  a_sqe_report: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (sqeIn != sqeStatus) |=> sqeChange && sqeStatus == $past(sqeIn))
    else $error("signal status not reported");

  a_car_report: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (!winOpen && rxActive != carrierStatus) |=> carrierChange)
    else $error("carrier status not reported");

  a_no_carrier: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (testState == aui_pls_pkg::T_TX && txEnd && !sawCarrier && !rxActive
      && !sqeIn) |=> testState == aui_pls_pkg::T_IDLE ##[1:900] !winOpen)
    else $error("test run without carrier");

  a_sqe_abort: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    ((testState == aui_pls_pkg::T_TX || testState == aui_pls_pkg::T_WAIT) && sqeIn)
      |=> !winOpen ##1 !sqeTestErr)
    else $error("test not aborted");

  a_win_pass: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    (winOpen && sqeIn) |-> ##[1:800] sqeTestOk)
    else $error("pass not reported");

  c_frame_sent: cover property (@(posedge clk) disable iff (!rstSync_b)
    txEnd);
  c_test_pass: cover property (@(posedge clk) disable iff (!rstSync_b)
    sqeTestOk);
  c_test_fail: cover property (@(posedge clk) disable iff (!rstSync_b)
    sqeTestErr);
  c_isolate: cover property (@(posedge clk) disable iff (!rstSync_b)
    monitor && ctlOutEn);

endmodule : aui_pls_line

`default_nettype wire

// File: rtl/aui_pls_pkg.sv
// Constants for the station-side line signalling block.
// Assumes a 200 MHz clock and a 10 Mb/s line rate.
package aui_pls_pkg;

  // Timing base
  localparam int CLK_NS   = 5;
  localparam int BIT_NS   = 100;
  localparam int BIT_CYC  = BIT_NS / CLK_NS;
  localparam int HALF_CYC = BIT_CYC / 2;

  // Idle hold of at least 2 bit times
  localparam int IDL_HOLD_BITS = 2;
  localparam int IDL_HOLD_CYC  = IDL_HOLD_BITS * BIT_CYC;

  // Idle detect bounds in tenths of a bit, chosen point in between
  localparam int IDL_MIN_TENTHS = 13;
  localparam int IDL_MAX_TENTHS = 16;
  localparam int IDL_DET_TENTHS = (IDL_MIN_TENTHS + IDL_MAX_TENTHS + 1) / 2;
  localparam int IDL_DET_CYC    = (IDL_DET_TENTHS * BIT_CYC) / 10;
  // Data circuit counts from the last mid-cell edge
  localparam int RX_IDL_CYC     = IDL_DET_CYC + HALF_CYC;
  localparam int MID_MIN_CYC    = (3 * BIT_CYC) / 4;
  // Control symbol split between CS0 and CS1 half periods
  localparam int CS_SPLIT_CYC   = (3 * HALF_CYC) / 2;

  // Quality-error test window
  localparam int WIN_MIN_NS = 4000;
  localparam int WIN_MAX_NS = 8000;
  localparam int WIN_CYC    = (WIN_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Frame header
  localparam logic [7:0] PRE_BYTE  = 8'h55;
  localparam logic [7:0] SFD_BYTE  = 8'hD5;
  localparam logic [2:0] HDR_LAST  = 3'h7;

  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int CTRL_MONITOR = 0;
  localparam logic CTRL_RESET = 1'b0;

  // Transmit states
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_REQ = 5'h02, TX_HDR = 5'h04,
    TX_DATA = 5'h08, TX_ETD = 5'h10
  } tx_state_type;

  // Quality-error test states
  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_TX = 4'h2, T_WAIT = 4'h4, T_WIN = 4'h8
  } test_state_type;

  // Control circuit symbols
  typedef enum logic [2:0] {
    SYM_IDL = 3'h1, SYM_CS1 = 3'h2, SYM_CS0 = 3'h4
  } sym_type;

endpackage : aui_pls_pkg

// File: tb/aui_mau_model.sv
// Behavioural attachment unit facing the station line pins.
// Assumes loopEn and sqeMode change only between frames.
`timescale 1ns/1ps
`default_nettype none

module aui_mau_model (
  input  wire logic       clk,
  input  wire logic       dataOut,
  input  wire logic       dataOutEn,
  input  wire logic       loopEn,
  input  wire logic [1:0] sqeMode,
  output logic            dataIn,
  output logic            ctlIn
);
  // Delay from end of output to the sqe burst
  localparam int TW_CYC = 100;
  int   cnt;
  logic enQ;
  logic burst;

  initial begin
    dataIn = 1'b0;
    ctlIn  = 1'b1;
    cnt    = 0;
    enQ    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Echo; a released line falls low, as the idle high droops away
  always @(posedge clk) begin
    enQ <= dataOutEn;
    cnt <= (enQ != dataOutEn) ? 0 : cnt + 1;
    dataIn <= loopEn && dataOutEn && dataOut;
  end

  // Ten bit burst after Tw, or mid-frame as a collision
  assign burst = (sqeMode == 2'h1 && !dataOutEn && cnt >= TW_CYC && cnt < TW_CYC + 200) ||
                 (sqeMode == 2'h2 && dataOutEn && cnt >= 200 && cnt < 400);

  ////////////////////////////////////////////////////////////////////////////
  // CS0 toggles every half bit, even duty; IDL rests high
  always @(posedge clk) begin
    if (burst && cnt % 10 == 0) ctlIn <= ~ctlIn;
    else if (!burst) ctlIn <= 1'b1;
  end
endmodule : aui_mau_model

`default_nettype wire

// File: tb/aui_pls_line_bench.sv
// Bench for the station line block: registers, frames, sqe test, monitor.
// Assumes the unit model closes the line pins.
`timescale 1ns/1ps
`default_nettype none

module aui_pls_line_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        macTxValid = 1'b0;
  logic        loopEn = 1'b1;
  logic [1:0]  sqeMode = 2'h1;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [7:0]  macTxData = 8'h0;
  logic [31:0] readdata;
  logic        waitrequest, macTxReady, rxValid, rxBit, carrierStatus, carrierChange;
  logic        sqeStatus, sqeChange, sqeTestOk, sqeTestErr, dataOut, dataOutEn;
  logic        dataIn, ctlOut, ctlOutEn, ctlIn;
  int          fails, compares, nCar, nSqe, nOk, nErr;
  logic        rxq[$];

  always #2.5 clk = ~clk;

  aui_pls_line aui_pls_line_inst (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .macTxValid(macTxValid), .macTxData(macTxData), .macTxReady(macTxReady),
    .rxValid(rxValid), .rxBit(rxBit), .carrierStatus(carrierStatus),
    .carrierChange(carrierChange), .sqeStatus(sqeStatus), .sqeChange(sqeChange),
    .sqeTestOk(sqeTestOk), .sqeTestErr(sqeTestErr), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .dataIn(dataIn), .ctlOut(ctlOut), .ctlOutEn(ctlOutEn),
    .ctlIn(ctlIn)
  );

  aui_mau_model aui_mau_model_inst (
    .clk(clk), .dataOut(dataOut), .dataOutEn(dataOutEn), .loopEn(loopEn),
    .sqeMode(sqeMode), .dataIn(dataIn), .ctlIn(ctlIn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event counters; pulses stand one cycle only
  always @(posedge clk) begin
    nCar += (carrierChange === 1'b1);
    nSqe += (sqeChange === 1'b1);
    nOk  += (sqeTestOk === 1'b1);
    nErr += (sqeTestErr === 1'b1);
    if (rxValid === 1'b1) rxq.push_back(rxBit);
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // One bus cycle; request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    @(posedge clk);
    // Only the watchdog ends a wait
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rd

  task automatic regs();
    logic [31:0] q;
    rd(4'h0, 32'h0, "ctrl reset");
    rd(4'h4, 32'h8, "status reset");
    rd(4'h8, 32'h0, "result reset");
    bus(1'b1, 4'h4, 32'hFF, q);
    rd(4'h4, 32'h8, "status ro");
    rd(4'hC, 32'h0, "unmapped");
    $display("test regs done");
  endtask : regs

  ////////////////////////////////////////////////////////////////////////////
  // Two byte frame: decode cells, check echo and the sqe test outcome
  task automatic frame(input logic [7:0] d0, input logic [7:0] d1, input int eOk,
                       input int eErr);
    logic [7:0]  b[10];
    logic [7:0]  a, got;
    logic [15:0] rx16;
    logic        h1;
    int          i, n, m, t;
    for (i = 0; i < 7; i++) b[i] = 8'h55;
    b[7] = 8'hD5;
    b[8] = d0;
    b[9] = d1;
    rxq.delete();
    nCar = 0;
    nSqe = 0;
    nOk  = 0;
    nErr = 0;
    i    = 0;
    @(posedge clk);
    macTxData  <= d0;
    macTxValid <= 1'b1;
    fork
      begin
        n = 0;
        while (i < 2 && n < 3000) begin
          @(posedge clk);
          n++;
          if (macTxReady === 1'b1) begin
            i++;
            macTxData <= d1;
            if (i == 2) macTxValid <= 1'b0;
          end
        end
      end
      begin
        m = 0;
        while (dataOutEn !== 1'b1 && m < 200) begin
          @(posedge clk);
          m++;
        end
        for (int k = 0; k < 80; k++) begin
          repeat (5) @(posedge clk);
          a[k % 8] = dataOut;
          repeat (10) @(posedge clk);
          got[k % 8] = dataOut;
          repeat (5) @(posedge clk);
          if (k % 8 == 7) begin
            chk("cell halves", 8'(~a), got);
            chk("tx byte", got, b[k / 8]);
          end
        end
        repeat (10) @(posedge clk);
        h1 = dataOut;
        repeat (20) @(posedge clk);
        chk("etd", {h1, dataOut, dataOutEn}, 3'h7);
      end
    join
    t = 0;
    for (n = 1; n <= 2000; n++) begin
      @(posedge clk);
      if (t == 0 && (sqeTestOk === 1'b1 || sqeTestErr === 1'b1)) t = n;
    end
    chk("bytes taken", i, 2);
    chk("ok pulses", nOk, eOk);
    chk("err pulses", nErr, eErr);
    chk("sqe changes", nSqe, (sqeMode != 2'h0) ? 2 : 0);
    chk("carrier seen", nCar != 0, loopEn);
    chk("carrier end", carrierStatus, 1'b0);
    if (eOk + eErr > 0) begin
      chk("window", t >= 790 && t <= 1600, 1'b1);
      rd(4'h8, 32'(eErr * 2 + eOk), "result");
    end
    rx16 = 16'h0;
    for (int k = 0; k < 16 && rxq.size() > 15; k++) rx16[k] = rxq[rxq.size() - 16 + k];
    if (loopEn) chk("rx data", rx16, {d1, d0});
    $display("test frame mode %0d done", sqeMode);
  endtask : frame

  // Monitor: CS0 on Control Out, data driver held off despite a request
  task automatic monitor_mode();
    logic [31:0] q;
    logic        h;
    int          e, bad;
    bus(1'b1, 4'h0, 32'h1, q);
    rd(4'h0, 32'h1, "ctrl");
    macTxValid <= 1'b1;
    repeat (40) @(posedge clk);
    e   = 0;
    bad = 0;
    h   = ctlOut;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      e   += (ctlOut !== h);
      bad += (dataOutEn !== 1'b0) + (ctlOutEn !== 1'b1);
      h    = ctlOut;
    end
    chk("cs0 edges", e, 20);
    chk("driver off", bad, 0);
    macTxValid <= 1'b0;
    bus(1'b1, 4'h0, 32'h0, q);
    repeat (100) @(posedge clk);
    $display("test monitor done");
  endtask : monitor_mode

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; model modes set between frames
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    regs();
    frame(8'hA3, 8'h0F, 1, 0);
    sqeMode <= 2'h0;
    frame(8'h5C, 8'hE1, 0, 1);
    sqeMode <= 2'h2;
    frame(8'h00, 8'hFF, 0, 0);
    sqeMode <= 2'h1;
    loopEn  <= 1'b0;
    frame(8'h81, 8'h7E, 0, 0);
    monitor_mode();
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : aui_pls_line_bench

`default_nettype wire
